// ### core/cacr_defs.vh
// Register offsets, field positions, key codes and address windows of the remap controller.
`ifndef CACR_DEFS_VH
`define CACR_DEFS_VH
`define CACR_OFS_CTRL 12'hfde
`define CACR_OFS_KEY 12'hfdf
`define CACR_ADDR_W 12
`define CACR_BIT_RST 0
`define CACR_BIT_RAM 1
`define CACR_BIT_VEC 2
`define CACR_KEY_RSTDIS 8'hb2
`define CACR_KEY_MAP 8'hd4
`define CACR_KEY_FCLR 8'h71
`define CACR_RAM_LO 17'h1_0040
`define CACR_RAM_HI 17'h1_0c3f
`define CACR_RAM_BASE 12'h040
`define CACR_VC_DEF_LO 17'h1_ffa0
`define CACR_VC_DEF_HI 17'h1_ffbf
`define CACR_IV_DEF_LO 17'h1_ffc2
`define CACR_IV_DEF_HI 17'h1_ffff
`define CACR_VC_REL_LO 17'h1_01a0
`define CACR_IV_REL_LO 17'h1_01c2
`define CACR_IV_REL_HI 17'h1_01fd
`define CACR_RESET_VEC 17'h1_fffe
`define CACR_ZERO8 8'h00
`define CACR_ZERO32 32'h0000_0000
`endif

// ### core/cacr_flag_reg.v
// Pending and active storage for one commit-controlled configuration bit.
`include "cacr_defs.vh"
module cacr_flag_reg (
  input wire core_clk_in,
  input wire nrst_in,
  input wire load_in,
  input wire pend_in,
  input wire commit_in,
  output reg pend_out,
  output reg act_out
);
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_out <= 1'b0;
      act_out <= 1'b0;
    end else begin
      if (load_in) begin
        pend_out <= pend_in;
      end
      if (commit_in) begin
        act_out <= load_in ? pend_in : pend_out;
      end
    end
  end
endmodule

// ### core/cacr_remap_ctrl.v
// Code-area remap controller: pending/commit registers on APB and code address steering.
`include "cacr_defs.vh"
module cacr_remap_ctrl (
  input wire core_clk_in,
  input wire nrst_in,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_prom_mode_in,
  input wire flag_clear_pend_in,
  input wire [16:0] code_addr_in,
  input wire [1:0] vec_kind_in,
  input wire [4:0] vec_index_in,
  output reg ram_code_sel_out,
  output reg [11:0] ram_code_addr_out,
  output reg [16:0] vec_addr_out,
  output reg reset_disable_out,
  output reg flag_clear_commit_out
);
  localparam VK_CALL = 2'd0;
  localparam VK_IRQ = 2'd1;
  localparam VK_RESET = 2'd2;

  // Two-stage synchroniser for the serial PROM mode strap.
  reg prom_meta_r;
  reg prom_sync_r;

  // Bus decode.
  wire [`CACR_ADDR_W-1:0] word_addr;
  wire setup_phase;
  wire access_phase;
  wire hit_ctrl;
  wire hit_key;
  wire hit_any;
  wire wr_ctrl;
  wire wr_key;
  wire rd_setup;

  // Key decode and commit strobes.
  wire [7:0] key;
  wire key_is_rst;
  wire key_is_map;
  wire key_is_fclr;
  wire [2:0] commit;

  // Pending and active configuration bits.
  wire [2:0] pend;
  wire [2:0] act;
  wire reset_disable_active;
  wire ram_map_active;
  wire vector_map_active;
  wire ram_map_eff;

  // Code fetch steering.
  wire above_ram_lo;
  wire below_ram_hi;
  wire [16:0] entry_ofs;
  reg [16:0] call_base;
  reg [16:0] irq_base;
  reg [16:0] call_addr;
  reg [16:0] irq_addr;
  reg [16:0] vec_nxt;
  reg ram_sel_nxt;
  reg [11:0] ram_addr_nxt;

  // Next values of the registered outputs.
  reg [31:0] rdata_nxt;
  reg pready_nxt;
  reg pslverr_nxt;
  reg flag_clear_nxt;

  // Setup is psel without penable; the slave answers in the following access cycle.
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable && pready;

  // Registers are word indexed, so the byte address drops its two low bits.
  assign word_addr = paddr[`CACR_ADDR_W+1:2];
  assign hit_ctrl = (word_addr == `CACR_OFS_CTRL);
  assign hit_key = (word_addr == `CACR_OFS_KEY);
  assign hit_any = hit_ctrl || hit_key;
  assign wr_ctrl = access_phase && pwrite && hit_ctrl;
  assign wr_key = access_phase && pwrite && hit_key;
  assign rd_setup = setup_phase && !pwrite;

  // Each key commits only its own bits; any other byte commits nothing.
  assign key = pwdata[7:0];
  assign key_is_rst = (key == `CACR_KEY_RSTDIS);
  assign key_is_map = (key == `CACR_KEY_MAP);
  assign key_is_fclr = (key == `CACR_KEY_FCLR);
  assign commit[`CACR_BIT_RST] = wr_key && key_is_rst;
  assign commit[`CACR_BIT_RAM] = wr_key && key_is_map;
  assign commit[`CACR_BIT_VEC] = wr_key && key_is_map;

  // Only bits 2..0 have storage, so upper writes vanish.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_bit
      cacr_flag_reg u_flag (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .load_in(wr_ctrl),
        .pend_in(pwdata[gi]),
        .commit_in(commit[gi]),
        .pend_out(pend[gi]),
        .act_out(act[gi])
      );
    end
  endgenerate

  assign reset_disable_active = act[`CACR_BIT_RST];
  assign ram_map_active = act[`CACR_BIT_RAM];
  assign vector_map_active = act[`CACR_BIT_VEC];

  // The mode strap comes from a pin and is synchronised first.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prom_meta_r <= 1'b0;
      prom_sync_r <= 1'b0;
    end else begin
      prom_meta_r <= serial_prom_mode_in;
      prom_sync_r <= prom_meta_r;
    end
  end

  // Serial PROM mode maps the RAM whatever the committed request says.
  assign ram_map_eff = ram_map_active || prom_sync_r;

  // Control reads return pending bits, status reads return active bits.
  always @* begin
    rdata_nxt = `CACR_ZERO32;
    case ({hit_key, hit_ctrl})
      2'b01: begin
        rdata_nxt[2:0] = pend;
      end
      2'b10: begin
        rdata_nxt[2:0] = act;
      end
      default: begin
        rdata_nxt = `CACR_ZERO32;
      end
    endcase
  end

  // Ready follows every setup cycle, so each access phase lasts one cycle.
  always @* begin
    pready_nxt = setup_phase;
  end

  // Unmapped addresses answer with an error and leave the flag bits alone; an unmapped read still loads zero into prdata.
  always @* begin
    pslverr_nxt = setup_phase && !hit_any;
  end

  // The flag-clear commit is a single-cycle strobe.
  always @* begin
    flag_clear_nxt = wr_key && key_is_fclr && flag_clear_pend_in;
  end

  // The code space is 17 bits wide with its own 64 KB at 0x10000.
  assign above_ram_lo = (code_addr_in >= `CACR_RAM_LO);
  assign below_ram_hi = (code_addr_in <= `CACR_RAM_HI);
  // Vector entries are two bytes apart.
  assign entry_ofs = {11'h000, vec_index_in, 1'b0};

  always @* begin
    ram_sel_nxt = ram_map_eff && above_ram_lo && below_ram_hi;
    ram_addr_nxt = code_addr_in[11:0] - `CACR_RAM_BASE;
  end

  // Relocation moves only the call and interrupt tables.
  always @* begin
    call_base = `CACR_VC_DEF_LO;
    irq_base = `CACR_IV_DEF_LO;
    if (vector_map_active) begin
      call_base = `CACR_VC_REL_LO;
      irq_base = `CACR_IV_REL_LO;
    end
  end

  always @* begin
    call_addr = call_base + entry_ofs;
    irq_addr = irq_base + entry_ofs;
  end

  // The reset vector never follows the relocation bit.
  always @* begin
    vec_nxt = `CACR_RESET_VEC;
    case (vec_kind_in)
      VK_CALL: begin
        vec_nxt = call_addr;
      end
      VK_IRQ: begin
        vec_nxt = irq_addr;
      end
      VK_RESET: begin
        vec_nxt = `CACR_RESET_VEC;
      end
      default: begin
        vec_nxt = `CACR_RESET_VEC;
      end
    endcase
  end

  // Bus handshake register.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready <= 1'b0;
    end else begin
      pready <= pready_nxt;
    end
  end

  // Bus error register.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= pslverr_nxt;
    end
  end

  // Read data is captured in the setup cycle and holds until the next read.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata <= `CACR_ZERO32;
    end else begin
      if (rd_setup) begin
        prdata <= rdata_nxt;
      end
    end
  end

  // RAM select for the previous fetch address.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ram_code_sel_out <= 1'b0;
    end else begin
      ram_code_sel_out <= ram_sel_nxt;
    end
  end

  // RAM offset for the previous fetch address.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ram_code_addr_out <= 12'h000;
    end else begin
      ram_code_addr_out <= ram_addr_nxt;
    end
  end

  // Vector fetch address for the previous kind and index.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vec_addr_out <= `CACR_RESET_VEC;
    end else begin
      vec_addr_out <= vec_nxt;
    end
  end

  // Active reset-disable level.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_disable_out <= 1'b0;
    end else begin
      reset_disable_out <= reset_disable_active;
    end
  end

  // Flag-clear commit strobe.
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_clear_commit_out <= 1'b0;
    end else begin
      flag_clear_commit_out <= flag_clear_nxt;
    end
  end
endmodule

// ### bench/cacr_remap_checker.sv
// Checker for the remap controller ports.
module cacr_remap_checker (
  input logic core_clk_in, nrst_in, psel, penable, pwrite, pready, serial_prom_mode_in,
  input logic flag_clear_pend_in, ram_code_sel_out, flag_clear_commit_out,
  input logic [31:0] paddr, pwdata, prdata,
  input logic [16:0] code_addr_in, vec_addr_out,
  input logic [1:0] vec_kind_in,
  input logic [4:0] vec_index_in,
  input logic [11:0] ram_code_addr_out
);
  logic [2:0] pend_r, act_r;
  logic wr, key, win;
  assign wr = psel && penable && pready && pwrite;
  assign key = wr && paddr == 32'h0000_3f7c;
  assign win = code_addr_in >= 17'h1_0040 && code_addr_in <= 17'h1_0c3f;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_r <= 3'h0;
      act_r <= 3'h0;
    end else if (wr && paddr == 32'h0000_3f78) begin
      pend_r <= pwdata[2:0];
    end else if (key && pwdata[7:0] == 8'hd4) begin
      act_r[2:1] <= pend_r[2:1];
    end else if (key && pwdata[7:0] == 8'hb2) begin
      act_r[0] <= pend_r[0];
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  chk_vec_default: assert property (!act_r[2] && vec_kind_in == 2'h0 |=>
    vec_addr_out == 17'h1_ffa0 + {$past(vec_index_in), 1'b0}) else $error("bad vector");
  chk_vec_reloc: assert property (act_r[2] && vec_kind_in == 2'h0 |=>
    vec_addr_out == 17'h1_01a0 + {$past(vec_index_in), 1'b0}) else $error("bad vector");
  chk_reset_vec: assert property (vec_kind_in == 2'h2 |=> vec_addr_out == 17'h1_fffe)
    else $error("bad reset vector");
  chk_ram_map: assert property (act_r[1] && win |=> ram_code_sel_out &&
    ram_code_addr_out == $past(code_addr_in[11:0]) - 12'h040) else $error("bad map");
  chk_ram_off: assert property ((!serial_prom_mode_in && !act_r[1]) [*4] |=>
    !ram_code_sel_out) else $error("ram mapped");
  chk_prom_map: assert property (serial_prom_mode_in [*4] ##0 win |=> ram_code_sel_out)
    else $error("ram unmapped");
  chk_stat_read: assert property (psel && !penable && !pwrite &&
    paddr == 32'h0000_3f7c |=> prdata == {29'h0, act_r}) else $error("bad status");
  chk_flag_clear: assert property (key && pwdata[7:0] == 8'h71 && flag_clear_pend_in |=>
    flag_clear_commit_out) else $error("no flag clear");
endmodule
bind cacr_remap_ctrl cacr_remap_checker u_chk (.*);

// ### bench/tb.sv
// Directed APB bench for the remap controller.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, nrst_in = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic serial_prom_mode_in = 0, flag_clear_pend_in = 0, ram_code_sel_out;
  logic reset_disable_out, flag_clear_commit_out;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [16:0] code_addr_in = 0, vec_addr_out;
  logic [1:0] vec_kind_in = 0;
  logic [4:0] vec_index_in = 0;
  logic [11:0] ram_code_addr_out;
  int err_count = 0, cmp_count = 0;
  localparam logic [13:0] CT = 14'h3f78, KY = 14'h3f7c;
  cacr_remap_ctrl DUT (.*);
  always #50 core_clk_in = ~core_clk_in;
  task summarize;
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {18'h0, a};
    pwdata <= {24'h0, d};
    @(posedge core_clk_in) penable <= 1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk_in);
  endtask
  task fe(input logic [16:0] a, input logic [1:0] k, input logic [4:0] i, input logic s,
    input logic [16:0] v);
    code_addr_in <= a;
    vec_kind_in <= k;
    vec_index_in <= i;
    @(posedge core_clk_in);
    #1 chk({vec_addr_out, ram_code_sel_out}, {v, s});
    @(posedge core_clk_in);
  endtask
  initial begin
    #100000 err_count++;
    summarize;
  end
  initial begin
    repeat (12) @(posedge core_clk_in);
    nrst_in <= 1;
    bus(0, KY, 8'h0);
    chk(rd, 32'h0);
    fe(17'h1_0040, 2'h0, 5'h1f, 1'b0, 17'h1_ffde);
    bus(1, CT, 8'hff);
    bus(0, CT, 8'h0);
    chk(rd, 32'h7);
    fe(17'h1_0040, 2'h1, 5'h1d, 1'b0, 17'h1_fffc);
    bus(1, KY, 8'h55);
    bus(0, KY, 8'h0);
    chk(rd, 32'h0);
    bus(1, KY, 8'hd4);
    bus(0, KY, 8'h0);
    chk(rd, 32'h6);
    fe(17'h1_0c3f, 2'h0, 5'h1f, 1'b1, 17'h1_01de);
    fe(17'h1_0c40, 2'h1, 5'h1d, 1'b0, 17'h1_01fc);
    flag_clear_pend_in <= 1;
    bus(1, KY, 8'h71);
    bus(1, KY, 8'hb2);
    bus(0, KY, 8'h0);
    chk({rd[31:1], reset_disable_out}, 32'h7);
    bus(0, 14'h0100, 8'h0);
    chk({se, rd[30:0]}, 32'h8000_0000);
    bus(1, CT, 8'h0);
    bus(1, KY, 8'hd4);
    serial_prom_mode_in <= 1;
    repeat (3) @(posedge core_clk_in);
    fe(17'h1_0040, 2'h0, 5'h0, 1'b1, 17'h1_ffa0);
    summarize;
  end
endmodule
